// ==== logic/sdic_regs.vh ====
// register offsets, field positions and reset values of the serial/dma interrupt chain
// assumes a plain 8-bit register address and 16-bit register data
`ifndef SDIC_REGS_VH
`define SDIC_REGS_VH

// register offsets
`define SDIC_CTRL 8'h00
`define SDIC_SVEC 8'h01
`define SDIC_DVEC 8'h02
`define SDIC_DMA_EN 8'h03
`define SDIC_DMA_STAT 8'h04
`define SDIC_RXS_ARM 8'h05
`define SDIC_RXS_STAT 8'h06
`define SDIC_TXS_ARM 8'h07
`define SDIC_TXS_STAT 8'h08
`define SDIC_IO_ARM 8'h09
`define SDIC_IO_EDGE 8'h0A
`define SDIC_IO_STAT 8'h0B
`define SDIC_DEV_ARM 8'h0C
`define SDIC_DEV_STAT 8'h0D
`define SDIC_RX_THR 8'h0E
`define SDIC_TX_THR 8'h0F
`define SDIC_TYPE_EN 8'h10
`define SDIC_PENDING 8'h11
`define SDIC_INSVC 8'h12

// control fields
`define SDIC_CTRL_SME 0
`define SDIC_CTRL_DME 1

// type indices, lower index wins
`define SDIC_T_DMA 0
`define SDIC_T_RXS 1
`define SDIC_T_RXD 2
`define SDIC_T_TXS 3
`define SDIC_T_TXD 4
`define SDIC_T_IOS 5
`define SDIC_T_DEV 6
`define SDIC_NTYPE 7

// vector field replaced by the type code, or by channel and source for dma
`define SDIC_VEC_CODE_LSB 1

// reset values
`define SDIC_RST_VEC 8'h00
`define SDIC_RST_ZERO 16'h0000

`endif

// ==== logic/sdic_top.v ====
// interrupt collector and daisy-chain end of a dual-channel dma plus serial controller
// assumes event inputs are one-cycle pulses synchronous to core_clk and a cpu-driven ack cycle
//
// Behaviour
// - winning acknowledge returns vector with 3-bit code
// - separate vectors for serial channel and dma
// - four enabled dma sources per channel
// - dma master enable gates all dma requests
// - six serial types with pending, service, enable
// - type enable and per-source arm both needed, rxd and txd need type enable only
// - serial master enable gates all serial requests
// - only requesting device with chain-in high answers
// - in-service bit blocks lower-priority requests
// - in-service set at ack when chain-in high
// - six armed receive status sources
// - receive data when fill exceeds threshold
// - six armed transmit status sources
// - transmit data when level below threshold
// - six pins, armed, selectable edge detection
// - pin edges seen whatever the pin function
// - four enabled device status sources
//
// Decided for this implementation: the plain strobed port and the register addresses.
`include "sdic_regs.vh"

module sdic_top #(
   parameter LVL_W = 6 // fifo level width, 32-deep fifos
) (
   input wire core_clk,
   input wire rst_n,
   // register port
   input wire [7:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   // dma events, one-cycle pulses: bit0 end of array/link, 1 end of buffer, 2 hw abort, 3 sw abort
   input wire [3:0] dma_rx_evt,
   input wire [3:0] dma_tx_evt,
   // receive status: hunt exit, idle, break/abort, code viol/eot/eom, parity/abort, overrun
   input wire [5:0] rxs_evt,
   // transmit status: preamble, idle, abort, eof/eom, crc, underrun
   input wire [5:0] txs_evt,
   input wire [LVL_W-1:0] rx_fifo_level,
   input wire [LVL_W-1:0] tx_fifo_level,
   // monitored pin levels, sampled regardless of pin function
   input wire rx_clock_pin,
   input wire tx_clock_pin,
   input wire rx_dma_request_pin,
   input wire tx_dma_request_pin,
   input wire carrier_detect_pin,
   input wire clear_to_send_pin,
   // device status: rx count underflow, phase lock sync, rate gen 1 zero, rate gen 0 zero
   input wire [3:0] dev_evt,
   // daisy chain; vec_oe qualifies vec_data, the vector means nothing while it is low
   output wire irq_n,
   input wire irq_ack_n,
   input wire chain_priority_in,
   output wire chain_priority_out,
   output reg [7:0] vec_data,
   output wire vec_oe
);

   // shared helpers

   // sticky update: hardware set wins over a write-one clear
   // clr_en is a decoded write strobe, wd picks the bits to clear
   function [15:0] sdic_sticky;
      input [15:0] cur;
      input [15:0] set;
      input clr_en;
      input [15:0] wd;
      begin
         sdic_sticky = (cur & ~(clr_en ? wd : 16'h0000)) | set;
      end
   endfunction

   // index of the lowest set bit, lowest index has highest priority
   // an empty vector gives zero, so callers qualify it with a live request
   function [2:0] sdic_first;
      input [7:0] v;
      integer k;
      begin
         sdic_first = 3'h0;
         for (k = 7; k >= 0; k = k - 1) begin
            if (v[k]) begin
               sdic_first = k[2:0];
            end
         end
      end
   endfunction

   // write strobe decode
   // shared by every write-one-clear register and the in-service bits
   function sdic_wr_hit;
      input [7:0] a;
      input [7:0] off;
      input wr;
      begin
         sdic_wr_hit = wr && (a == off);
      end
   endfunction

   // priority runs dma first, then the six serial types in index order
   // a type in service holds off itself and every type below it, so a
   // nested request only gets through from a higher type
   // vector layout: bits 7:4 and 0 from the base, bits 3:1 carry the code
   // limitation: one code per acknowledge, software reads status for the rest
   // trade-off: the code names the type only, not the source inside it,
   // except for dma where channel and source fit in the three code bits

   // registers
   reg [1:0] ctrl_q; // master enables: serial, dma
   reg [7:0] svec_q; // serial vector base
   reg [7:0] dvec_q; // dma vector base
   reg [7:0] dma_en_q; // rx in [3:0], tx in [7:4]
   reg [7:0] dma_stat_q; // sticky dma events
   reg [5:0] rxs_arm_q;
   reg [5:0] rxs_stat_q;
   reg [5:0] txs_arm_q;
   reg [5:0] txs_stat_q;
   reg [5:0] io_arm_q;
   reg [11:0] io_edge_q; // two bits a pin: rising, falling
   reg [5:0] io_stat_q;
   reg [3:0] dev_arm_q;
   reg [3:0] dev_stat_q;
   reg [LVL_W-1:0] rx_fill_threshold_reg;
   reg [LVL_W-1:0] tx_drain_threshold_reg;
   reg [6:0] type_enable; // bit per type, dma included
   reg [6:0] in_service_flag;
   reg [5:0] pin_prev_q; // last pin levels
   reg ack_prev_q; // ack level last cycle
   reg ack_win_q; // this device owns the ack cycle
   reg irq_req_q; // registered request

   // combinational
   wire [5:0] pins;
   wire [5:0] pin_rise;
   wire [5:0] pin_fall;
   reg [5:0] io_hit;
   reg [6:0] pending_flag;
   reg [6:0] req;
   reg [6:0] blocked;
   wire serial_master_enable;
   wire dma_master_enable;
   wire ack_start;
   wire [2:0] win_type;
   wire [2:0] dma_code;
   wire [7:0] dma_set; // rx sources in 3:0, tx in 7:4
   // next values of the sticky registers before slicing to width
   wire [15:0] insvc_nxt;
   wire [15:0] rxs_nxt;
   wire [15:0] txs_nxt;
   wire [15:0] io_nxt;
   wire [15:0] dev_nxt;
   integer i; // edge loop
   integer j; // request loop

   assign serial_master_enable = ctrl_q[`SDIC_CTRL_SME];
   assign dma_master_enable = ctrl_q[`SDIC_CTRL_DME];

   // pin edges come straight from the pins, so pin mode cannot hide them
   // history loads from the pins during reset, so a pin resting high
   // gives no false edge on the first cycle after release
   // limitation: an edge shorter than one core_clk cycle may be missed
   assign pins = {clear_to_send_pin, carrier_detect_pin, tx_dma_request_pin,
                  rx_dma_request_pin, tx_clock_pin, rx_clock_pin};
   assign pin_rise = pins & ~pin_prev_q;
   assign pin_fall = ~pins & pin_prev_q;

   // per-pin edge choice: rising, falling or both
   // bit 2i picks rising, bit 2i+1 falling; both set reports either
   always @* begin
      for (i = 0; i < 6; i = i + 1) begin
         io_hit[i] = (pin_rise[i] & io_edge_q[2*i]) | (pin_fall[i] & io_edge_q[2*i+1]);
      end
   end

   assign dma_set = {dma_tx_evt, dma_rx_evt};

   // pending per type; arms and source enables gate contribution
   // rxd and txd follow the fifo levels directly and are not sticky,
   // they drop by themselves once the fifo moves back across the threshold
   // a level exactly at the threshold requests neither
   always @* begin
      pending_flag[`SDIC_T_DMA] = |(dma_stat_q & dma_en_q);
      pending_flag[`SDIC_T_RXS] = |(rxs_stat_q & rxs_arm_q);
      pending_flag[`SDIC_T_RXD] = rx_fifo_level > rx_fill_threshold_reg;
      pending_flag[`SDIC_T_TXS] = |(txs_stat_q & txs_arm_q);
      pending_flag[`SDIC_T_TXD] = tx_fifo_level < tx_drain_threshold_reg;
      pending_flag[`SDIC_T_IOS] = |(io_stat_q & io_arm_q);
      pending_flag[`SDIC_T_DEV] = |(dev_stat_q & dev_arm_q);
   end

   // requests: type enable, master enables, and service blocking
   // the request is registered once, so irq_n is free of glitches and the
   // ack edge judges the same request that the chain has already seen
   always @* begin
      for (j = 0; j < 7; j = j + 1) begin
         // any type in service at equal or higher priority blocks this one
         blocked[j] = |({1'b0, in_service_flag} & ((8'h02 << j) - 8'h01));
         req[j] = pending_flag[j] & type_enable[j] & ~blocked[j];
      end
      req[`SDIC_T_DMA] = req[`SDIC_T_DMA] & dma_master_enable;
      req[6:1] = req[6:1] & {6{serial_master_enable}};
   end

   assign win_type = sdic_first({1'b0, req});
   // dma code names channel and first source, {tx, source}
   // tx sources sit above the rx ones, so rx wins when both are set
   assign dma_code = sdic_first(dma_stat_q & dma_en_q);

   // next values of the sticky registers; a write-one clear loses to a set
   assign insvc_nxt = sdic_sticky({9'h000, in_service_flag}, 16'h0000,
      sdic_wr_hit(reg_addr, `SDIC_INSVC, reg_wr), reg_wdata);
   assign rxs_nxt = sdic_sticky({10'h000, rxs_stat_q}, {10'h000, rxs_evt},
      sdic_wr_hit(reg_addr, `SDIC_RXS_STAT, reg_wr), reg_wdata);
   assign txs_nxt = sdic_sticky({10'h000, txs_stat_q}, {10'h000, txs_evt},
      sdic_wr_hit(reg_addr, `SDIC_TXS_STAT, reg_wr), reg_wdata);
   assign io_nxt = sdic_sticky({10'h000, io_stat_q}, {10'h000, io_hit},
      sdic_wr_hit(reg_addr, `SDIC_IO_STAT, reg_wr), reg_wdata);
   assign dev_nxt = sdic_sticky({12'h000, dev_stat_q}, {12'h000, dev_evt},
      sdic_wr_hit(reg_addr, `SDIC_DEV_STAT, reg_wr), reg_wdata);

   // first cycle of an ack cycle
   assign ack_start = ~irq_ack_n & ack_prev_q;

   // chain outputs
   // chain_priority_out is combinational so the inhibit ripples down the
   // chain in the same cycle as it arrives from upstream
   assign irq_n = ~irq_req_q;
   // inhibit downstream while requesting or in service
   assign chain_priority_out = chain_priority_in & ~irq_req_q & ~(|in_service_flag);
   // drive vector only while we own the ack
   assign vec_oe = ack_win_q & ~irq_ack_n;

   // chain state, vector latch and in-service bits
   // ack start is the first low cycle of irq_ack_n; one win per low period
   // trade-off: the vector is latched at that edge and held, so the bus sees
   // a stable value for the whole ack even if a new event arrives meanwhile
   always @(posedge core_clk) begin
      if (!rst_n) begin
         ack_prev_q <= 1'b1;
         ack_win_q <= 1'b0;
         irq_req_q <= 1'b0;
         vec_data <= `SDIC_RST_VEC;
         in_service_flag <= 7'h00;
         pin_prev_q <= pins; // no false edge from a pin resting high
      end else begin
         ack_prev_q <= irq_ack_n;
         pin_prev_q <= pins;
         irq_req_q <= |req;
         if (irq_ack_n) begin
            // ack over, release the bus
            ack_win_q <= 1'b0;
         end
         // write-one clear of in-service lets lower types request again
         in_service_flag <= insvc_nxt[6:0];
         // a refused ack leaves vec_oe low and the old vector in place
         // win only with chain-in high and a live request
         if (ack_start && chain_priority_in && irq_req_q && (|req)) begin
            ack_win_q <= 1'b1;
            in_service_flag[win_type] <= 1'b1;
            if (win_type == `SDIC_T_DMA) begin
               // dma vector, code field replaced
               vec_data <= {dvec_q[7:4], dma_code, dvec_q[0]};
            end else begin
               // serial vector, code is type index minus one
               vec_data <= {svec_q[7:4], win_type - 3'h1, svec_q[0]};
            end
         end
      end
   end

   // sticky status registers; set wins over a write-one clear
   // every event is recorded even while unarmed, so arming later still
   // reports it; the arm and enable bits only gate the pending flags
   // software should clear a status bit before it ends the service
   always @(posedge core_clk) begin
      if (!rst_n) begin
         dma_stat_q <= 8'h00;
         rxs_stat_q <= 6'h00;
         txs_stat_q <= 6'h00;
         io_stat_q <= 6'h00;
         dev_stat_q <= 4'h0;
      end else begin
         dma_stat_q <= sdic_stat8(dma_stat_q, dma_set, `SDIC_DMA_STAT);
         rxs_stat_q <= rxs_nxt[5:0];
         txs_stat_q <= txs_nxt[5:0];
         io_stat_q <= io_nxt[5:0];
         dev_stat_q <= dev_nxt[3:0];
      end
   end

   // eight-bit sticky wrapper tied to the register port
   // it reads the register port directly, so call it from clocked code only
   function [7:0] sdic_stat8;
      input [7:0] cur;
      input [7:0] set;
      input [7:0] off;
      reg [15:0] r;
      begin
         r = sdic_sticky({8'h00, cur}, {8'h00, set}, sdic_wr_hit(reg_addr, off, reg_wr), reg_wdata);
         sdic_stat8 = r[7:0];
      end
   endfunction

   // software-written control registers
   // status, pending and in-service offsets are not stored here; writes to
   // them either clear bits elsewhere or are ignored
   // unmapped offsets change nothing
   always @(posedge core_clk) begin
      if (!rst_n) begin
         ctrl_q <= 2'b00;
         svec_q <= `SDIC_RST_VEC;
         dvec_q <= `SDIC_RST_VEC;
         dma_en_q <= 8'h00;
         rxs_arm_q <= 6'h00;
         txs_arm_q <= 6'h00;
         io_arm_q <= 6'h00;
         io_edge_q <= 12'h000;
         dev_arm_q <= 4'h0;
         rx_fill_threshold_reg <= {LVL_W{1'b0}};
         tx_drain_threshold_reg <= {LVL_W{1'b0}};
         type_enable <= 7'h00;
      end else if (reg_wr) begin
         case (reg_addr)
            `SDIC_CTRL: ctrl_q <= reg_wdata[1:0];
            `SDIC_SVEC: svec_q <= reg_wdata[7:0];
            `SDIC_DVEC: dvec_q <= reg_wdata[7:0];
            `SDIC_DMA_EN: dma_en_q <= reg_wdata[7:0];
            `SDIC_RXS_ARM: rxs_arm_q <= reg_wdata[5:0];
            `SDIC_TXS_ARM: txs_arm_q <= reg_wdata[5:0];
            `SDIC_IO_ARM: io_arm_q <= reg_wdata[5:0];
            `SDIC_IO_EDGE: io_edge_q <= reg_wdata[11:0];
            `SDIC_DEV_ARM: dev_arm_q <= reg_wdata[3:0];
            `SDIC_RX_THR: rx_fill_threshold_reg <= reg_wdata[LVL_W-1:0];
            `SDIC_TX_THR: tx_drain_threshold_reg <= reg_wdata[LVL_W-1:0];
            `SDIC_TYPE_EN: type_enable <= reg_wdata[6:0];
            default: ctrl_q <= ctrl_q;
         endcase
      end
   end

   // read data, valid the cycle after the strobe; unmapped reads zero
   // reg_rdata holds its last value between reads, the master only
   // relies on it in the cycle after the read strobe
   // reading a status register does not clear it
   always @(posedge core_clk) begin
      if (!rst_n) begin
         reg_rdata <= `SDIC_RST_ZERO;
      end else if (reg_rd) begin
         case (reg_addr)
            `SDIC_CTRL: reg_rdata <= {14'h0000, ctrl_q};
            `SDIC_SVEC: reg_rdata <= {8'h00, svec_q};
            `SDIC_DVEC: reg_rdata <= {8'h00, dvec_q};
            `SDIC_DMA_EN: reg_rdata <= {8'h00, dma_en_q};
            `SDIC_DMA_STAT: reg_rdata <= {8'h00, dma_stat_q};
            `SDIC_RXS_ARM: reg_rdata <= {10'h000, rxs_arm_q};
            `SDIC_RXS_STAT: reg_rdata <= {10'h000, rxs_stat_q};
            `SDIC_TXS_ARM: reg_rdata <= {10'h000, txs_arm_q};
            `SDIC_TXS_STAT: reg_rdata <= {10'h000, txs_stat_q};
            `SDIC_IO_ARM: reg_rdata <= {10'h000, io_arm_q};
            `SDIC_IO_EDGE: reg_rdata <= {4'h0, io_edge_q};
            `SDIC_IO_STAT: reg_rdata <= {10'h000, io_stat_q};
            `SDIC_DEV_ARM: reg_rdata <= {12'h000, dev_arm_q};
            `SDIC_DEV_STAT: reg_rdata <= {12'h000, dev_stat_q};
            `SDIC_RX_THR: reg_rdata <= {{(16-LVL_W){1'b0}}, rx_fill_threshold_reg};
            `SDIC_TX_THR: reg_rdata <= {{(16-LVL_W){1'b0}}, tx_drain_threshold_reg};
            `SDIC_TYPE_EN: reg_rdata <= {9'h000, type_enable};
            `SDIC_PENDING: reg_rdata <= {9'h000, pending_flag};
            `SDIC_INSVC: reg_rdata <= {9'h000, in_service_flag};
            default: reg_rdata <= `SDIC_RST_ZERO;
         endcase
      end
   end

endmodule

// ==== bench/sdic_cpu_model.sv ====
// host cpu and upstream chain neighbour: runs acknowledge cycles
// assumes core_clk is shared with the collector and the bench calls ack_cycle
module sdic_cpu_model (
   input wire logic core_clk,
   input wire logic vec_oe,
   input wire logic [7:0] vec_data,
   output logic irq_ack_n,
   output logic chain_priority_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle: no ack, upstream allows
   initial begin
      irq_ack_n = 1'b1;
      chain_priority_in = 1'b1;
   end
   // ack held low three cycles so the vector has settled before it is taken
   task automatic ack_cycle(input logic up_ok, output logic oe, output logic [7:0] v);
      @(posedge core_clk);
      chain_priority_in <= up_ok;
      irq_ack_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      oe = vec_oe;
      v = vec_data;
      irq_ack_n <= 1'b1;
      chain_priority_in <= 1'b1;
   endtask
endmodule

// ==== bench/sdic_top_props.sv ====
// assertions on the daisy-chain pins of the interrupt collector
// assumes it is bound to sdic_top and sees only its ports
module sdic_top_props (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic irq_n,
   input wire logic irq_ack_n,
   input wire logic chain_priority_in,
   input wire logic chain_priority_out,
   input wire logic [7:0] vec_data,
   input wire logic vec_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ack start: a high cycle then low
   sequence ack_start;
      irq_ack_n ##1 !irq_ack_n;
   endsequence
   // a won acknowledge shows as the enable rising
   sequence won;
      !vec_oe ##1 vec_oe;
   endsequence
   chk_chain_in_low: assert property (!chain_priority_in |-> !chain_priority_out)
      else $error("chain out high while chain in low");
   chk_serving_blocks: assert property (vec_oe |-> !chain_priority_out)
      else $error("chain out high while vector driven");
   chk_oe_needs_ack: assert property (vec_oe |-> !irq_ack_n)
      else $error("vector driven outside ack");
   chk_no_chain_win: assert property (ack_start ##0 !chain_priority_in |=> !vec_oe)
      else $error("vector driven with chain in low");
   chk_no_req_win: assert property (ack_start ##0 irq_n |=> !vec_oe)
      else $error("vector driven without request");
   chk_win_start: assert property (won |-> $past(chain_priority_in) && $past(irq_ack_n, 2))
      else $error("win outside an ack start");
   chk_oe_holds: assert property (vec_oe |=> vec_oe || irq_ack_n)
      else $error("vector dropped during ack");
   chk_vec_steady: assert property (vec_oe ##1 vec_oe |-> $stable(vec_data))
      else $error("vector changed while driven");
endmodule

// ==== bench/sdic_top_tb.sv ====
// self-checking bench of the serial/dma interrupt collector
// assumes the cpu model and checker are compiled first
`include "sdic_regs.vh"
module sdic_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
   logic reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0] dma_rx_evt = 4'h0, dma_tx_evt = 4'h0, dev_evt = 4'h0;
   logic [5:0] rxs_evt = 6'h00, txs_evt = 6'h00, pins = 6'h3F; // monitored pins rest high
   logic [5:0] rx_lvl = 6'h00, tx_lvl = 6'h14; // tx idles at or above any threshold used
   logic irq_n, irq_ack_n, cpi, cpo, vec_oe, oe;
   logic [7:0] vec_data, v, sbase, dbase;
   int bad_count = 0, n_compared = 0, s, thr;
   integer seed = 32'hE54AA00F;
   // arm and status offsets per type; zero for level-driven types
   logic [7:0] arm_tab [7] = '{8'h03, 8'h05, 8'h00, 8'h07, 8'h00, 8'h09, 8'h0C};
   logic [7:0] stat_tab [7] = '{8'h04, 8'h06, 8'h00, 8'h08, 8'h00, 8'h0B, 8'h0D};
   always #5 core_clk = ~core_clk;
   sdic_top uut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_rx_evt(dma_rx_evt),
      .dma_tx_evt(dma_tx_evt), .rxs_evt(rxs_evt), .txs_evt(txs_evt), .rx_fifo_level(rx_lvl),
      .tx_fifo_level(tx_lvl), .rx_clock_pin(pins[0]), .tx_clock_pin(pins[1]),
      .rx_dma_request_pin(pins[2]), .tx_dma_request_pin(pins[3]), .carrier_detect_pin(pins[4]),
      .clear_to_send_pin(pins[5]), .dev_evt(dev_evt), .irq_n(irq_n), .irq_ack_n(irq_ack_n),
      .chain_priority_in(cpi), .chain_priority_out(cpo), .vec_data(vec_data), .vec_oe(vec_oe));
   sdic_cpu_model cpu (.core_clk(core_clk), .vec_oe(vec_oe), .vec_data(vec_data),
      .irq_ack_n(irq_ack_n), .chain_priority_in(cpi));
   task automatic chk_bit(input string nm, input logic e, input logic g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %0b seen %0b", nm, e, g);
      end
   endtask
   task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [15:0] dat);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= dat;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // read data is taken in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [15:0] dat);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 dat = reg_rdata;
   endtask
   // event to request takes two cycles; margin for the registered output
   task automatic settle;
      repeat (4) @(posedge core_clk);
      #1;
   endtask
   // one event of type t, source s; level types move one step past the threshold
   task automatic fire(input int t, input int k);
      @(posedge core_clk);
      case (t)
         0: {dma_tx_evt, dma_rx_evt} <= 8'h01 << k;
         1: rxs_evt <= 6'h01 << k;
         2: rx_lvl <= 6'(thr + 1);
         3: txs_evt <= 6'h01 << k;
         4: tx_lvl <= 6'(thr - 1);
         5: pins[k] <= ~pins[k];
         default: dev_evt <= 4'h1 << k;
      endcase
      @(posedge core_clk);
      {dma_tx_evt, dma_rx_evt} <= 8'h00;
      rxs_evt <= 6'h00;
      txs_evt <= 6'h00;
      dev_evt <= 4'h0;
   endtask
   // base bits kept, bits 3:1 carry type index minus one, or channel and source for dma
   function automatic logic [15:0] exp_vec(input int t, input int k);
      logic [7:0] b;
      logic [2:0] c;
      b = (t == 0) ? dbase : sbase;
      c = (t == 0) ? k[2:0] : 3'(t - 1);
      return {8'h00, b[7:4], c, b[0]};
   endfunction
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      complete_run();
   end
   initial begin
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      wr(8'h20, 16'hFFFF);
      wr(`SDIC_PENDING, 16'hFFFF);
      for (int a = 0; a < 20; a++) begin
         rd((a == 19) ? 8'h20 : 8'(a), d);
         chk_word("reset value", 16'h0000, d);
      end
      cpu.ack_cycle(1'b1, oe, v);
      chk_bit("vec_oe no request", 1'b0, oe);
      chk_bit("chain out idle", 1'b1, cpo);
      $display("test reset done");
      sbase = 8'($random(seed));
      dbase = sbase ^ 8'hF0;
      wr(`SDIC_SVEC, {8'h00, sbase});
      wr(`SDIC_DVEC, {8'h00, dbase});
      wr(`SDIC_TYPE_EN, 16'h007F);
      wr(`SDIC_CTRL, 16'h0003);
      // every type, random source, through arm, master, ack and clear
      for (int t = 0; t < 7; t++) begin
         s = $unsigned($random(seed)) % ((t == 0) ? 8 : (t == 6) ? 4 : 6);
         thr = 1 + $unsigned($random(seed)) % 20;
         wr(`SDIC_RX_THR, 16'(thr));
         wr(`SDIC_TX_THR, 16'(thr));
         wr(`SDIC_IO_EDGE, 16'h0003 << (2 * s));
         fire(t, s);
         settle();
         if (arm_tab[t] != 8'h00) begin
            chk_bit("irq_n unarmed", 1'b1, irq_n);
            wr(arm_tab[t], 16'h0001 << s);
            settle();
         end
         chk_bit("irq_n armed", 1'b0, irq_n);
         chk_bit("chain out pending", 1'b0, cpo);
         rd(`SDIC_PENDING, d);
         chk_word("pending", 16'h0001 << t, d);
         wr(`SDIC_TYPE_EN, 16'h007F ^ (16'h0001 << t));
         settle();
         chk_bit("irq_n type off", 1'b1, irq_n);
         wr(`SDIC_TYPE_EN, 16'h007F);
         wr(`SDIC_CTRL, (t == 0) ? 16'h0001 : 16'h0002);
         settle();
         chk_bit("irq_n master off", 1'b1, irq_n);
         wr(`SDIC_CTRL, 16'h0003);
         settle();
         cpu.ack_cycle(1'b1, oe, v);
         chk_bit("vec_oe", 1'b1, oe);
         chk_word("vector", exp_vec(t, s), {8'h00, v});
         rx_lvl <= 6'h00;
         tx_lvl <= 6'h14;
         settle();
         chk_bit("irq_n in service", 1'b1, irq_n);
         rd(`SDIC_INSVC, d);
         chk_word("in service", 16'h0001 << t, d);
         if (arm_tab[t] != 8'h00) begin
            wr(stat_tab[t], 16'h0001 << s);
            wr(arm_tab[t], 16'h0000);
         end
         wr(`SDIC_INSVC, 16'h0001 << t);
         settle();
         chk_bit("irq_n cleared", 1'b1, irq_n);
         $display("test type %0d done", t);
      end
      // receive status in service holds off device status
      fire(1, 0);
      wr(`SDIC_RXS_ARM, 16'h0001);
      settle();
      cpu.ack_cycle(1'b1, oe, v);
      chk_word("vector rxs", exp_vec(1, 0), {8'h00, v});
      wr(`SDIC_DEV_ARM, 16'h0001);
      fire(6, 0);
      settle();
      chk_bit("irq_n lower blocked", 1'b1, irq_n);
      // receive status handled: its status is cleared before its service ends
      wr(`SDIC_RXS_STAT, 16'h0001);
      wr(`SDIC_INSVC, 16'h0002);
      settle();
      chk_bit("irq_n resumed", 1'b0, irq_n);
      cpu.ack_cycle(1'b0, oe, v);
      chk_bit("vec_oe chain low", 1'b0, oe);
      rd(`SDIC_INSVC, d);
      chk_word("in service refused", 16'h0000, d);
      cpu.ack_cycle(1'b1, oe, v);
      chk_word("vector resumed", exp_vec(6, 0), {8'h00, v});
      $display("test priority done");
      complete_run();
   end
endmodule
bind sdic_top sdic_top_props chk (.core_clk(core_clk), .rst_n(rst_n), .irq_n(irq_n), .irq_ack_n(irq_ack_n),
   .chain_priority_in(chain_priority_in), .chain_priority_out(chain_priority_out), .vec_data(vec_data),
   .vec_oe(vec_oe));
